//--- rtl/fsd_defs.vh
/*
 * Constants for the fail-safe diagnostic status bank: frame layout, register
 * addresses, field positions, reset values and counter limits.
 * Assumes a 16-bit serial frame, MSB first, sampled on the rising link clock.
 */
// How it works
// RULE_01: Reset pin stuck-high flag, clear on read.
// RULE_02: External reset flag, clear on read.
// RULE_03: Safe-output two-bit fault code, clear on read.
// RULE_04: Watchdog error count; six forces reset, clears.
// RULE_05: Good refresh count; seven decrements reset count.
// RULE_06: Reset error count readable, one after reset.
// RULE_07: I/O protocol failure flags, clear on read.
// RULE_08: Resistor string flag cleared only by reset.
// RULE_09: Enabled interrupt condition pulses interrupt pin low.
// RULE_10: Controller configures interrupt pulse during initialisation.
// RULE_11: Masked interrupt sources produce no pulse.
// RULE_12: Controller request over link produces pulse.
// RULE_13: Each I/O pin state change raises event.
// RULE_14: Each I/O pin wake-up raises event.
// RULE_15: Bus wake-up raises interrupt event.
// RULE_16: Transmit dominant, receive recessive raise events.
// RULE_17: Bus clamped dominant raises event.
// RULE_18: Secured link check failure raises event.
// RULE_19: Frame not sixteen clocks flags count error.
// RULE_20: Malformed, late init write, bad address flagged.
// RULE_21: Wrong frame parity flags parity error.
// RULE_22: Report pre-regulator buck or boost mode.
// RULE_23: Three watchdog registers refresh after their access.
// RULE_24: I/O summary is OR of four flags.
// RULE_25: Read frame: rw, address, parity, flags, data.
// RULE_26: Read-clear flags clear after being shifted out.
`ifndef FSD_DEFS_VH
`define FSD_DEFS_VH
`define FSD_FRAME_BITS    5'h10
`define FSD_RW_BIT        15
`define FSD_ADDR_HI       14
`define FSD_ADDR_LO       9
`define FSD_PAR_BIT       8
`define FSD_ADDR_ANSWER   6'h28
`define FSD_ADDR_INITWD   6'h2B
`define FSD_ADDR_DIAG1    6'h2C
`define FSD_ADDR_WDCNT    6'h2D
`define FSD_ADDR_DIAG2    6'h2E
`define FSD_ADDR_INTCFG   6'h30
`define FSD_ADDR_INTMASK  6'h31
`define FSD_ADDR_INTREQ   6'h32
`define FSD_ADDR_EVENTS   6'h33
`define FSD_WDERR_LIMIT   3'h6
`define FSD_REFRESH_LIMIT 3'h7
`define FSD_RSTERR_INIT   3'h1
`define FSD_PULSE_DEF     8'h10
`define FSD_MASK_DEF      8'h00
`define FSD_SAFE_NONE     2'h0
`endif

//--- rtl/fsd_status_bank.v
/*
 * Fail-safe diagnostic status bank with a 16-bit serial slave and a low
 * interrupt pulse. Holds diagnostic flags, watchdog counters and I/O monitor
 * flags, checks each frame, and gathers events into masked interrupt pulses.
 * Assumes the serial pins and all fault inputs are asynchronous to clk and
 * that the link clock is far slower than clk (125 ns against 8 ns).
 */
`include "fsd_defs.vh"

module fsd_status_bank #(
    parameter PULSE_W = 8
)(
    // Clock, reset and enable.
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    // Serial link pins.
    input  wire        sclk,
    input  wire        cs_n,
    input  wire        mosi,
    output reg         miso_reg,
    // Fault and event inputs, asynchronous levels.
    input  wire        reset_pin_short_high,
    input  wire        reset_pin_low_ext,
    input  wire        safe_pin_short_high,
    input  wire        safe_pin_short_low,
    input  wire        wd_bad_refresh,
    input  wire        wd_good_refresh,
    input  wire [2:0]  io_proto_fail,
    input  wire        io_rstring_fail,
    input  wire [5:0]  io_level,
    input  wire [5:0]  io_wakeup,
    input  wire        bus_wakeup,
    input  wire        txd_dominant,
    input  wire        rxd_recessive,
    input  wire        bus_dominant,
    input  wire        buck_mode,
    input  wire        init_phase,
    // Outputs.
    output reg         interrupt_pulse_pin_n_reg,
    output reg         wd_reset_req_reg
);

    localparam NI = 28;
    localparam ST_IDLE  = 3'b001;
    localparam ST_FRAME = 3'b010;
    localparam ST_END   = 3'b100;

    // Two-stage synchronisers; logic reads the second stage and a delayed copy of it for edges.
    reg [NI-1:0] s1_reg;
    reg [NI-1:0] s2_reg;
    wire [NI-1:0] raw = {init_phase, buck_mode, bus_dominant, rxd_recessive,
        txd_dominant, bus_wakeup, io_wakeup, io_level, io_rstring_fail,
        io_proto_fail, wd_good_refresh, wd_bad_refresh, safe_pin_short_low,
        safe_pin_short_high, reset_pin_low_ext, reset_pin_short_high};
    reg [2:0] ls1_reg;
    reg [2:0] ls2_reg;
    reg       sclk_d_reg;
    reg [NI-1:0] d_reg;

    always @(posedge clk)
    begin
        if (rst)
        begin
            s1_reg <= {NI{1'b0}};
            s2_reg <= {NI{1'b0}};
            d_reg <= {NI{1'b0}};
            ls1_reg <= 3'b010;
            ls2_reg <= 3'b010;
            sclk_d_reg <= 1'b0;
        end
        else if (ce)
        begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            d_reg <= s2_reg;
            ls1_reg <= {sclk, cs_n, mosi};
            ls2_reg <= ls1_reg;
            sclk_d_reg <= ls2_reg[2];
        end
    end

    wire sc = ls2_reg[2];
    wire csn = ls2_reg[1];
    wire sdi = ls2_reg[0];
    wire rise = sc & ~sclk_d_reg;
    wire fall = ~sc & sclk_d_reg;
    wire [NI-1:0] rise_ev = s2_reg & ~d_reg;
    wire [5:0] io_chg = s2_reg[15:10] ^ d_reg[15:10];
    wire in_init = s2_reg[27];

    // Even parity over the whole frame with the parity bit included.
    function par_ok;
        input [15:0] f;
        begin
            par_ok = ~^f;
        end
    endfunction

    // Diagnostic and counter state.
    reg       rst_hi_reg, rst_ext_reg, io_rs_reg;
    reg [1:0] safe_code_reg;
    reg [2:0] io_fail_reg;
    reg [2:0] wd_err_reg, wd_ref_reg, rst_err_reg;
    reg [7:0] snap_cnt_reg, snap_diag2_reg;
    reg       fs_clk_err_reg, fs_req_err_reg, fs_par_err_reg, fs_sec_err_reg;
    reg [7:0] int_mask_reg, pulse_len_reg, int_pend_reg;
    reg [7:0] pulse_cnt_reg;
    reg [2:0] state_reg;
    reg [4:0] bits_reg;
    reg [15:0] rx_reg, tx_reg;
    reg        int_req_reg;

    wire       io_summary = |io_fail_reg | io_rs_reg; // RULE_24
    wire [7:0] glob = {fs_clk_err_reg | fs_req_err_reg | fs_par_err_reg,
        1'b0, 1'b0, 1'b0, io_summary, 1'b0, 1'b0, 1'b0};
    wire [5:0] rx_addr = rx_reg[`FSD_ADDR_HI:`FSD_ADDR_LO];
    wire       rx_wr = rx_reg[`FSD_RW_BIT];
    wire       done = (state_reg == ST_END);
    wire       good_len = (bits_reg == `FSD_FRAME_BITS);
    wire       read_ok = done & good_len & ~rx_wr;

    // Answer byte; after seven link bits the address sits in the low six
    // bits of the shift register, so it is decoded from there.
    wire [5:0] hdr_addr = rx_reg[5:0]; // RULE_25
    reg [7:0]  rd_data;
    reg        legal;
    always @*
    begin
        rd_data = 8'h00;
        case (hdr_addr)
            `FSD_ADDR_DIAG1:   rd_data = {rst_ext_reg, rst_hi_reg, 1'b0,
                                          safe_code_reg, 3'b000};
            `FSD_ADDR_WDCNT:   rd_data = snap_cnt_reg;
            `FSD_ADDR_DIAG2:   rd_data = snap_diag2_reg;
            `FSD_ADDR_ANSWER:  rd_data = {7'h00, io_summary};
            `FSD_ADDR_INITWD:  rd_data = {fs_sec_err_reg, fs_clk_err_reg,
                                          fs_req_err_reg, fs_par_err_reg, 4'h0};
            `FSD_ADDR_INTCFG:  rd_data = pulse_len_reg;
            `FSD_ADDR_INTMASK: rd_data = int_mask_reg;
            `FSD_ADDR_EVENTS:  rd_data = int_pend_reg;
            default:           rd_data = 8'h00;
        endcase
    end

    // Legality of the whole frame, judged once chip select has risen.
    always @*
    begin
        legal = 1'b1;
        case (rx_addr)
            `FSD_ADDR_INTREQ:  legal = rx_wr;
            `FSD_ADDR_DIAG1, `FSD_ADDR_WDCNT, `FSD_ADDR_DIAG2, `FSD_ADDR_ANSWER,
            `FSD_ADDR_INITWD, `FSD_ADDR_INTCFG, `FSD_ADDR_INTMASK,
            `FSD_ADDR_EVENTS:  legal = 1'b1;
            default:           legal = 1'b0;
        endcase
        // Read-only diagnostic registers refuse writes.
        if (rx_wr && (rx_addr == `FSD_ADDR_DIAG1 || rx_addr == `FSD_ADDR_WDCNT
            || rx_addr == `FSD_ADDR_DIAG2 || rx_addr == `FSD_ADDR_EVENTS))
            legal = 1'b0;
        // Read frames must carry a zero data byte.
        if (!rx_wr && rx_reg[7:0] != 8'h00)
            legal = 1'b0;
        if (rx_wr && !in_init && (rx_addr == `FSD_ADDR_INTCFG
            || rx_addr == `FSD_ADDR_INITWD))
            legal = 1'b0;
    end

    // Frame engine; captures on the link rising edge, shifts out on falling.
    // A frame is judged once chip select rises, so counting errors cover both
    // short and long frames.
    always @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            bits_reg <= 5'h00;
            rx_reg <= 16'h0000;
            tx_reg <= 16'h0000;
            miso_reg <= 1'b0;
        end
        else if (ce)
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (!csn)
                    begin
                        state_reg <= ST_FRAME;
                        bits_reg <= 5'h00;
                        tx_reg <= {glob, 8'h00};
                        miso_reg <= glob[7];
                    end
                end
                ST_FRAME:
                begin
                    if (csn)
                        state_reg <= ST_END;
                    else if (rise)
                    begin
                        rx_reg <= {rx_reg[14:0], sdi};
                        if (bits_reg != 5'h1F)
                            bits_reg <= bits_reg + 5'h01;
                        // Seven shifts are done, so the answer byte goes in
                        // where the next falling edge will pick up its MSB.
                        if (bits_reg == 5'h07)
                            tx_reg[14:7] <= rd_data; // RULE_25
                    end
                    else if (fall)
                    begin
                        tx_reg <= {tx_reg[14:0], 1'b0};
                        miso_reg <= tx_reg[14];
                    end
                end
                ST_END:
                    state_reg <= ST_IDLE;
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // Flags and counters; in each flag a new event wins over the clear.
    wire rd1 = read_ok & (rx_addr == `FSD_ADDR_DIAG1);
    wire rd2 = read_ok & (rx_addr == `FSD_ADDR_DIAG2);
    wire wd_hit = done & good_len & (rx_addr == `FSD_ADDR_ANSWER
        || rx_addr == `FSD_ADDR_WDCNT || rx_addr == `FSD_ADDR_DIAG2);
    wire wr_ok = done & good_len & rx_wr & legal & par_ok(rx_reg);

    always @(posedge clk)
    begin
        if (rst)
        begin
            rst_hi_reg <= 1'b0;
            rst_ext_reg <= 1'b0;
            safe_code_reg <= `FSD_SAFE_NONE;
            io_fail_reg <= 3'b000;
            io_rs_reg <= 1'b0;
            wd_err_reg <= 3'h0;
            wd_ref_reg <= 3'h0;
            rst_err_reg <= `FSD_RSTERR_INIT; // RULE_06
            wd_reset_req_reg <= 1'b0;
            snap_cnt_reg <= 8'h00;
            snap_diag2_reg <= 8'h00;
            fs_clk_err_reg <= 1'b0;
            fs_req_err_reg <= 1'b0;
            fs_par_err_reg <= 1'b0;
            fs_sec_err_reg <= 1'b0;
            int_mask_reg <= `FSD_MASK_DEF;
            pulse_len_reg <= `FSD_PULSE_DEF;
            int_req_reg <= 1'b0;
        end
        else if (ce)
        begin
            // Cleared only after the frame that shipped them has ended.
            rst_hi_reg <= s2_reg[0] | (rst_hi_reg & ~rd1); // RULE_01 RULE_26
            rst_ext_reg <= rise_ev[1] | (rst_ext_reg & ~rd1); // RULE_02
            if (s2_reg[2])
                safe_code_reg <= 2'b10; // RULE_03
            else if (s2_reg[3] && !safe_code_reg[1])
                safe_code_reg <= 2'b01;
            else if (rd1)
                safe_code_reg <= `FSD_SAFE_NONE;
            io_fail_reg <= s2_reg[8:6] | (io_fail_reg & {3{~rd2}}); // RULE_07
            io_rs_reg <= io_rs_reg | s2_reg[9]; // RULE_08
            wd_reset_req_reg <= 1'b0;
            if (rise_ev[4])
            begin
                if (wd_err_reg + 3'h1 == `FSD_WDERR_LIMIT)
                begin
                    wd_err_reg <= 3'h0; // RULE_04
                    wd_reset_req_reg <= 1'b1;
                end
                else
                    wd_err_reg <= wd_err_reg + 3'h1;
            end
            else if (rise_ev[5])
            begin
                if (wd_ref_reg + 3'h1 == `FSD_REFRESH_LIMIT)
                begin
                    wd_ref_reg <= 3'h0; // RULE_05
                    if (rst_err_reg != 3'h0)
                        rst_err_reg <= rst_err_reg - 3'h1;
                end
                else
                    wd_ref_reg <= wd_ref_reg + 3'h1;
            end
            if (wd_hit)
            begin
                snap_cnt_reg <= {wd_err_reg, 1'b0, wd_ref_reg, 1'b0}; // RULE_23
                snap_diag2_reg <= {rst_err_reg, 1'b0, io_fail_reg[2:1],
                                   io_rs_reg, io_fail_reg[0]};
            end
            if (done)
            begin
                fs_clk_err_reg <= fs_clk_err_reg | ~good_len; // RULE_19
                fs_par_err_reg <= fs_par_err_reg
                    | (good_len & ~par_ok(rx_reg)); // RULE_21
                fs_req_err_reg <= fs_req_err_reg | (good_len & ~legal); // RULE_20
                // Secured check: the low nibble of a request must mirror bits.
                fs_sec_err_reg <= fs_sec_err_reg | (wr_ok
                    & (rx_addr == `FSD_ADDR_INTREQ)
                    & (rx_reg[3:0] != {~rx_reg[5], ~rx_reg[4], rx_reg[7:6]}));
            end
            int_req_reg <= 1'b0;
            if (wr_ok && rx_addr == `FSD_ADDR_INTMASK)
                int_mask_reg <= rx_reg[7:0]; // RULE_11
            if (wr_ok && rx_addr == `FSD_ADDR_INTCFG)
                pulse_len_reg <= rx_reg[7:0]; // RULE_10
            if (wr_ok && rx_addr == `FSD_ADDR_INTREQ)
                int_req_reg <= 1'b1; // RULE_12
        end
    end

    // Event groups: io change, io wake, bus wake, txd, rxd, bus dominant,
    // secured error, buck/boost change.
    wire sec_rise = done & good_len & wr_ok & (rx_addr == `FSD_ADDR_INTREQ)
        & (rx_reg[3:0] != {~rx_reg[5], ~rx_reg[4], rx_reg[7:6]});
    wire [7:0] events = {s2_reg[26] ^ d_reg[26], // RULE_22
        sec_rise,                                // RULE_18
        rise_ev[25],                             // RULE_17
        rise_ev[24],                             // RULE_16
        rise_ev[23],
        rise_ev[22],                             // RULE_15
        |rise_ev[21:16],                         // RULE_14
        |io_chg};                                // RULE_13
    wire fire = |(events & ~int_mask_reg) | int_req_reg; // RULE_09

    // Pending list clears on read of the event register; an event wins.
    // A single counter times the low pulse; events during a pulse merge.
    always @(posedge clk)
    begin
        if (rst)
        begin
            int_pend_reg <= 8'h00;
            pulse_cnt_reg <= 8'h00;
            interrupt_pulse_pin_n_reg <= 1'b1;
        end
        else if (ce)
        begin
            int_pend_reg <= events | (int_pend_reg
                & ~{8{read_ok & (rx_addr == `FSD_ADDR_EVENTS)}});
            if (fire && pulse_cnt_reg == 8'h00)
            begin
                pulse_cnt_reg <= (pulse_len_reg == 8'h00) ? 8'h01 : pulse_len_reg;
                interrupt_pulse_pin_n_reg <= 1'b0;
            end
            else if (pulse_cnt_reg != 8'h00)
            begin
                pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
                interrupt_pulse_pin_n_reg <= (pulse_cnt_reg == 8'h01);
            end
        end
    end

endmodule

//--- verification/fsd_spi_master.sv
/*
 * Serial master model facing the diagnostic bank: 125 ns link clock.
 * Assumes the bank samples mosi on rising sclk and shifts miso on falling.
 */
module fsd_spi_master (
    // Link pins.
    output logic sclk = 1'b0,
    output logic cs_n = 1'b1,
    output logic mosi = 1'b0,
    input  wire  miso
);
    timeunit 1ns;
    timeprecision 100ps;

    // One frame, MSB first; sclk stands low outside frames.
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        #3 cs_n = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            mosi = tx[15 - (i % 16)];
            #62.5 sclk = 1'b1;
            rx = {rx[14:0], miso};
            #62.5 sclk = 1'b0;
        end
        #62.5 cs_n = 1'b1;
        mosi = ~mosi; // An idle line must not look like the last bit.
        #250;
    endtask
endmodule

//--- verification/fsd_status_bank_properties.sv
/*
 * Port checker for the diagnostic bank: reset levels, watchdog reset request,
 * interrupt pulse shape and cause, serial output hold.
 * Assumes ce stays high and the pulse length keeps its default of 16 clocks.
 */
module fsd_status_bank_properties #(
    parameter PULSE_W = 8
)(
    // Clock and reset.
    input wire       clk,
    input wire       rst,
    // Serial link.
    input wire       sclk,
    input wire       cs_n,
    input wire       miso_reg,
    // Causes.
    input wire       wd_bad_refresh,
    input wire [5:0] io_level,
    input wire [5:0] io_wakeup,
    input wire       bus_wakeup,
    input wire       txd_dominant,
    input wire       rxd_recessive,
    input wire       bus_dominant,
    input wire       buck_mode,
    // Outputs.
    input wire       interrupt_pulse_pin_n_reg,
    input wire       wd_reset_req_reg
);
    localparam int PULSE_CLKS = 16;
    logic [7:0] low_cnt, quiet_cnt, hi_cnt, since_six;
    logic [2:0] bad_cnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Run lengths, quiet time since any cause, and an own tally of bad refreshes.
    always @(posedge clk)
    begin
        low_cnt <= (rst || interrupt_pulse_pin_n_reg) ? 8'h00 : low_cnt + 8'h01;
        hi_cnt <= (rst || !sclk) ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hff};
        if (rst || $changed({io_level, io_wakeup, bus_wakeup, txd_dominant, rxd_recessive,
                             bus_dominant, buck_mode, cs_n}))
            quiet_cnt <= 8'h00;
        else if (quiet_cnt != 8'hff)
            quiet_cnt <= quiet_cnt + 8'h01;
        if (rst)
            bad_cnt <= 3'h0;
        else if ($rose(wd_bad_refresh))
            bad_cnt <= (bad_cnt == 3'h5) ? 3'h0 : bad_cnt + 3'h1;
        if (rst)
            since_six <= 8'hff;
        else if ($rose(wd_bad_refresh) && bad_cnt == 3'h5)
            since_six <= 8'h00;
        else if (since_six != 8'hff)
            since_six <= since_six + 8'h01;
    end

    sequence int_fall;
        $fell(interrupt_pulse_pin_n_reg);
    endsequence
    sequence int_low8;
        !interrupt_pulse_pin_n_reg [*8];
    endsequence
    sequence sixth_bad;
        $rose(wd_bad_refresh) && bad_cnt == 3'h5;
    endsequence

    chk_reset_values: assert property ($fell(rst) |-> interrupt_pulse_pin_n_reg
        && !wd_reset_req_reg && !miso_reg) else $error("outputs not at reset level");
    chk_wdreq_due: assert property (
        sixth_bad |-> ##[1:12] wd_reset_req_reg) else $error("no reset request at six");
    chk_wdreq_cause: assert property (
        $rose(wd_reset_req_reg) |-> since_six <= 8'h0c) else $error("reset request early");
    chk_wdreq_single: assert property (
        wd_reset_req_reg |=> !wd_reset_req_reg) else $error("reset request too long");
    chk_int_min_low: assert property (
        int_fall |-> int_low8) else $error("interrupt pulse too short");
    chk_int_width: assert property (
        $rose(interrupt_pulse_pin_n_reg) && !$past(rst) |-> low_cnt == PULSE_CLKS)
        else $error("interrupt pulse length wrong");
    chk_int_has_cause: assert property (
        int_fall |-> quiet_cnt < 8'h10) else $error("interrupt pulse without cause");
    chk_miso_holds: assert property (
        !cs_n && hi_cnt >= 8'h05 |-> $stable(miso_reg)) else $error("miso moved");
endmodule

//--- verification/fsd_status_bank_tb.sv
/*
 * Self-checking bench for the diagnostic bank: fault inputs, frames through
 * the master model, register reads and interrupt pulses are judged here.
 * Assumes the master model and the checker are compiled before this file.
 */
`include "fsd_defs.vh"
module fsd_status_bank_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, sclk, cs_n, mosi, miso_reg, int_n, wd_req;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        init_phase = 1'b1;
    logic        buck_mode = 1'b0;
    logic [9:0]  flt = 10'h000;
    logic [15:0] ev = 16'h0000;
    int          err_total = 0;
    int          check_count = 0;
    int          req_count = 0;

    fsd_status_bank i_fsd_status_bank (
        .clk, .rst, .ce, .sclk, .cs_n, .mosi, .miso_reg, .init_phase, .buck_mode,
        .reset_pin_short_high(flt[0]), .reset_pin_low_ext(flt[1]),
        .safe_pin_short_high(flt[2]), .safe_pin_short_low(flt[3]),
        .wd_bad_refresh(flt[4]), .wd_good_refresh(flt[5]),
        .io_proto_fail(flt[8:6]), .io_rstring_fail(flt[9]),
        .io_level(ev[5:0]), .io_wakeup(ev[11:6]), .bus_wakeup(ev[12]),
        .txd_dominant(ev[13]), .rxd_recessive(ev[14]), .bus_dominant(ev[15]),
        .interrupt_pulse_pin_n_reg(int_n), .wd_reset_req_reg(wd_req)
    );
    fsd_spi_master i_fsd_spi_master (.sclk, .cs_n, .mosi, .miso(miso_reg));

    // Reset requests are counted so a scenario can judge how many arrived.
    always @(posedge clk)
        req_count <= req_count + (wd_req === 1'b1);
    // Interrupt falls are counted, so a pulse that ends inside a frame is not missed.
    logic        int_q = 1'b1;
    int          int_falls = 0;
    always @(posedge clk)
    begin
        int_q <= int_n;
        int_falls <= int_falls + (int_q === 1'b1 && int_n === 1'b0);
    end

    task automatic tick(input int n); repeat (n) @(posedge clk); endtask
    task automatic chk(input logic [15:0] got, exp, mask);
        check_count++;
        if ((got & mask) !== (exp & mask))
        begin
            err_total++;
            $display("MISMATCH t=%0t got %h want %h mask %h", $time, got, exp, mask);
        end
    endtask
    task automatic rd(input logic [5:0] a, output logic [15:0] r);
        i_fsd_spi_master.xfer({1'b0, a, ^a, 8'h00}, 16, r);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [15:0] r;
        i_fsd_spi_master.xfer({1'b1, a, ~^{a, d}, d}, 16, r);
    endtask
    // Pulses the fault inputs in m, n times, long enough for the synchronisers.
    task automatic hit(input logic [9:0] m, input int n);
        repeat (n)
        begin
            @(posedge clk) flt <= m;
            tick(8);
            @(posedge clk) flt <= 10'h000;
            tick(8);
        end
    endtask
    // Watches a fixed window for one interrupt pulse, or for none.
    task automatic int_seen(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (60) @(posedge clk) if (int_n === 1'b0) seen = 1'b1;
        chk({15'h0000, seen}, {15'h0000, exp}, 16'h0001);
    endtask

    task automatic t_reset_values;
        logic [15:0] r;
        rd(`FSD_ADDR_DIAG2, r);
        rd(`FSD_ADDR_DIAG2, r);
        chk(r, 16'h0020, 16'h08ff);
        rd(`FSD_ADDR_DIAG1, r);
        chk(r, 16'h0000, 16'h00ff);
    endtask
    task automatic t_pin_flags;
        logic [15:0] r;
        hit(10'h00b, 1);
        rd(`FSD_ADDR_DIAG1, r);
        chk(r, 16'h00c8, 16'h00d8);
        rd(`FSD_ADDR_DIAG1, r);
        chk(r, 16'h0000, 16'h00d8);
        hit(10'h004, 1);
        rd(`FSD_ADDR_DIAG1, r);
        chk(r, 16'h0010, 16'h0010);
    endtask
    task automatic t_io_flags;
        logic [15:0] r;
        hit(10'h3c0, 1);
        rd(`FSD_ADDR_DIAG2, r);
        rd(`FSD_ADDR_DIAG2, r);
        chk(r, 16'h082f, 16'h08ff);
        rd(`FSD_ADDR_DIAG2, r);
        rd(`FSD_ADDR_DIAG2, r);
        chk(r, 16'h0822, 16'h08ff);
    endtask
    task automatic t_watchdog;
        logic [15:0] r;
        int          n0;
        hit(10'h020, 10);
        hit(10'h010, 3);
        rd(`FSD_ADDR_WDCNT, r);
        rd(`FSD_ADDR_WDCNT, r);
        chk(r, 16'h0066, 16'h00ff);
        rd(`FSD_ADDR_DIAG2, r);
        chk(r, 16'h0000, 16'h00e0);
        n0 = req_count;
        hit(10'h010, 3);
        chk(16'(req_count - n0), 16'h0001, 16'hffff);
        rd(`FSD_ADDR_WDCNT, r);
        rd(`FSD_ADDR_WDCNT, r);
        chk(r, 16'h0000, 16'h00e0);
    endtask
    task automatic t_link_errors;
        logic [15:0] fr [5] = '{16'h5600, 16'h5600, 16'h5700, 16'h7e00, 16'he010};
        int          nb [5] = '{15, 17, 16, 16, 16};
        logic [15:0] bt [5] = '{16'h8040, 16'h8040, 16'h8010, 16'h8020, 16'h8020};
        logic [15:0] r;
        for (int i = 0; i < 5; i++)
        begin
            // The link flags are sticky, so a reset lets each frame show its own.
            @(posedge clk) rst <= 1'b1;
            tick(3);
            rst <= 1'b0;
            tick(3);
            i_fsd_spi_master.xfer(fr[i], nb[i], r);
            rd(`FSD_ADDR_INITWD, r);
            chk(r, bt[i], 16'h80f0);
        end
    endtask
    task automatic t_interrupts;
        logic [15:0] r;
        int          b;
        for (int i = 0; i < 16; i++)
        begin
            b = (i < 6) ? 0 : (i < 12) ? 1 : i - 10;
            @(posedge clk) ev[i] <= 1'b1;
            int_seen(1'b1);
            rd(`FSD_ADDR_EVENTS, r);
            chk(r, 16'h0001 << b, 16'h0001 << b);
            @(posedge clk) ev[i] <= 1'b0;
            if (i < 6)
                int_seen(1'b1);
            else
                tick(60);
            rd(`FSD_ADDR_EVENTS, r);
        end
        wr(`FSD_ADDR_INTMASK, 8'h04);
        @(posedge clk) ev[12] <= 1'b1;
        int_seen(1'b0);
        @(posedge clk) ev[12] <= 1'b0;
        rd(`FSD_ADDR_EVENTS, r);
        wr(`FSD_ADDR_INTMASK, `FSD_MASK_DEF);
        tick(60);
        b = int_falls;
        wr(`FSD_ADDR_INTREQ, 8'h0c);
        tick(40);
        chk(16'(int_falls - b), 16'h0001, 16'hffff);
        rd(`FSD_ADDR_EVENTS, r);
        chk(r, 16'h0000, 16'h0040);
        b = int_falls;
        wr(`FSD_ADDR_INTREQ, 8'h00);
        tick(40);
        chk(16'(int_falls - b), 16'h0001, 16'hffff);
        rd(`FSD_ADDR_EVENTS, r);
        chk(r, 16'h0040, 16'h0040);
        rd(`FSD_ADDR_INITWD, r);
        chk(r, 16'h8080, 16'h8080);
        @(posedge clk) buck_mode <= 1'b1;
        tick(60);
        rd(`FSD_ADDR_EVENTS, r);
        chk(r, 16'h0080, 16'h0080);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Free-running system clock.
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Hang guard, far beyond the normal run length.
    initial
    begin
        #600us;
        err_total++;
        print_verdict;
    end
    // Main sequence: reset, initial configuration, then the scenarios.
    initial
    begin
        tick(12);
        rst <= 1'b0;
        tick(5);
        wr(`FSD_ADDR_INTCFG, `FSD_PULSE_DEF);
        @(posedge clk) init_phase <= 1'b0;
        t_reset_values;
        t_pin_flags;
        t_io_flags;
        t_watchdog;
        t_link_errors;
        t_interrupts;
        print_verdict;
    end
endmodule

bind fsd_status_bank fsd_status_bank_properties #(.PULSE_W(PULSE_W)) i_props (
    .clk, .rst, .sclk, .cs_n, .miso_reg, .wd_bad_refresh, .io_level, .io_wakeup,
    .bus_wakeup, .txd_dominant, .rxd_recessive, .bus_dominant, .buck_mode,
    .interrupt_pulse_pin_n_reg, .wd_reset_req_reg
);
